// ==== logic/rfie_core.sv ====
// Overview of operation
// - The return op pops the hardware return stack by one level.
// - The popped top-of-stack value becomes the new program counter.
// - The return op sets the high or the low global interrupt enable.
// - With the restore bit set, shadows are copied to W, flags and bank select.
// - With the restore bit clear, W, flags and bank select keep their values.
// - Upper and high program counter latches are never touched by the return.
// - One word, restore bit in bit 0; two cycles, pop and enable in first Q4.
`timescale 1ns/10ps
`default_nettype none
module rfie_core #(
   parameter int PCW   = rfie_pkg::RFIE_PCW,
   parameter int SPW   = rfie_pkg::RFIE_SPW,
   parameter int DEPTH = rfie_pkg::RFIE_DEPTH,
   parameter int QDIV  = rfie_pkg::RFIE_QDIV
) (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic      [31:0] hrdata,
   output logic             hresp
);
   import rfie_pkg::*;

   typedef struct packed {
      rfie_state_t    st;
      logic [1:0]     qn;
      logic           sbit;
      logic [15:0]    iword;
      logic [PCW-1:0] pc;
      logic [SPW-1:0] sp;
      logic [7:0]     w;
      logic [7:0]     flags;
      logic [3:0]     bank_select_reg;
      logic [7:0]     working_shadow;
      logic [7:0]     flags_shadow;
      logic [3:0]     bank_select_shadow;
      logic           global_high_int_enable;
      logic           periph_low_int_enable;
      logic           prio;
      logic [4:0]     pc_upper_latch;
      logic [7:0]     pc_high_latch;
      logic           dp_wr;
      logic [7:0]     dp_addr;
      logic           done;
      logic           ready;
      logic           resp;
      logic [31:0]    rdata;
   } rfie_core_t;

   rfie_core_t     r, n;
   logic           qtick;
   logic [PCW-1:0] top_of_return_stack;
   logic           mem_we;
   logic           bus_wr;
   logic           addr_ok;
   logic           ex_fire;

   function automatic logic is_return_op(input logic [15:0] word);
      is_return_op = (word & RFIE_RET_MASK) == RFIE_RET_OP;
   endfunction : is_return_op

   // ----------------------------------------------------------------
   // Quarter-phase timing and return stack
   // ----------------------------------------------------------------
   rfie_qtick #(.QDIV(QDIV)) u_qtick (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .qtick   (qtick)
   );

   rfie_stack_mem #(.DW(PCW), .AW(SPW)) u_stack (
      .mclk    (mclk),
      .we      (mem_we),
      .waddr   (r.sp),
      .wdata   (hwdata[PCW-1:0]),
      .raddr   (r.sp - 1'b1),
      .rdata_r (top_of_return_stack)
   );

   assign bus_wr  = r.dp_wr;
   assign addr_ok = hsel && htrans[1] && hready && hsize == {1'b0, RFIE_HSIZE_W};
   assign ex_fire = r.st == RFIE_ST_CYC1 && r.qn == RFIE_LAST_Q && qtick;

   // ----------------------------------------------------------------
   // Bus slave and execution
   // ----------------------------------------------------------------
   always_comb begin
      n        = r;
      n.done   = 1'b0;
      n.ready  = 1'b1;
      n.resp   = 1'b0;
      n.dp_wr  = addr_ok && hwrite;
      mem_we   = 1'b0;
      if (addr_ok) begin
         n.dp_addr = haddr[7:0];
      end
      // Read data is formed in the address phase so it stands in the data phase
      if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            RFIE_A_INSTR: n.rdata = {16'h0000, r.iword};
            RFIE_A_CTRL: begin
               n.rdata = 32'h0000_0000;
               n.rdata[RFIE_CTL_GIEH] = r.global_high_int_enable;
               n.rdata[RFIE_CTL_GIEL] = r.periph_low_int_enable;
               n.rdata[RFIE_CTL_PRIO] = r.prio;
               n.rdata[RFIE_CTL_BUSY] = r.st != RFIE_ST_IDLE;
               n.rdata[RFIE_CTL_SP_LSB +: SPW] = r.sp;
            end
            RFIE_A_PC:    n.rdata = 32'(r.pc);
            RFIE_A_PUSH:  n.rdata = 32'(top_of_return_stack);
            RFIE_A_WREG:  n.rdata = {24'h000000, r.w};
            RFIE_A_FLAGS: n.rdata = {24'h000000, r.flags};
            RFIE_A_BANK:  n.rdata = {28'h0000000, r.bank_select_reg};
            RFIE_A_WSH:   n.rdata = {24'h000000, r.working_shadow};
            RFIE_A_FSH:   n.rdata = {24'h000000, r.flags_shadow};
            RFIE_A_BSH:   n.rdata = {28'h0000000, r.bank_select_shadow};
            RFIE_A_PCLAT: n.rdata = {19'h00000, r.pc_upper_latch, r.pc_high_latch};
            default:      n.rdata = 32'h0000_0000;
         endcase
      end
      // Data phase of a write
      if (r.dp_wr) begin
         case (r.dp_addr)
            RFIE_A_INSTR: begin
               if (r.st == RFIE_ST_IDLE) begin
                  n.iword = hwdata[15:0];
               end
            end
            RFIE_A_CTRL: begin
               n.global_high_int_enable = hwdata[RFIE_CTL_GIEH];
               n.periph_low_int_enable  = hwdata[RFIE_CTL_GIEL];
               n.prio                   = hwdata[RFIE_CTL_PRIO];
            end
            RFIE_A_PC:    n.pc = hwdata[PCW-1:0];
            RFIE_A_PUSH: begin
               // Pushes are refused while executing or when the stack is full
               if (r.st == RFIE_ST_IDLE && r.sp != SPW'(DEPTH)) begin
                  mem_we = 1'b1;
                  n.sp   = r.sp + 1'b1;
               end
            end
            RFIE_A_WREG:  n.w                  = hwdata[7:0];
            RFIE_A_FLAGS: n.flags              = hwdata[7:0];
            RFIE_A_BANK:  n.bank_select_reg    = hwdata[3:0];
            RFIE_A_WSH:   n.working_shadow     = hwdata[7:0];
            RFIE_A_FSH:   n.flags_shadow       = hwdata[7:0];
            RFIE_A_BSH:   n.bank_select_shadow = hwdata[3:0];
            RFIE_A_PCLAT: begin
               n.pc_high_latch  = hwdata[7:0];
               n.pc_upper_latch = hwdata[RFIE_PCLAT_UP +: 5];
            end
            default: ;
         endcase
      end
      // Instruction sequencer: two cycles of four quarters each
      case (r.st)
         RFIE_ST_IDLE: begin
            if (r.dp_wr && r.dp_addr == RFIE_A_INSTR && is_return_op(hwdata[15:0])) begin
               n.st   = RFIE_ST_CYC1;
               n.qn   = 2'h0;
               n.sbit = hwdata[RFIE_SBIT];
            end
         end
         RFIE_ST_CYC1: begin
            if (qtick) begin
               n.qn = r.qn + 2'h1;
               if (r.qn == RFIE_LAST_Q) begin
                  n.st = RFIE_ST_CYC2;
                  n.pc = top_of_return_stack;
                  // Underflow leaves the pointer at zero rather than wrapping
                  if (r.sp != '0) begin
                     n.sp = r.sp - 1'b1;
                  end
                  // The high level ISR ran with its enable cleared, so that one returns
                  if (!r.prio || !r.global_high_int_enable) begin
                     n.global_high_int_enable = 1'b1;
                  end else begin
                     n.periph_low_int_enable = 1'b1;
                  end
                  if (r.sbit) begin
                     n.w               = r.working_shadow;
                     n.flags           = r.flags_shadow;
                     n.bank_select_reg = r.bank_select_shadow;
                  end
                  // Without the restore bit W, flags and bank are left to the bus
                  // Latches pc_upper_latch and pc_high_latch are not assigned here
               end
            end
         end
         RFIE_ST_CYC2: begin
            if (qtick) begin
               n.qn = r.qn + 2'h1;
               if (r.qn == RFIE_LAST_Q) begin
                  n.st   = RFIE_ST_IDLE;
                  n.done = 1'b1;
               end
            end
         end
         default: n.st = RFIE_ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         r                        <= '0;
         r.st                     <= RFIE_ST_IDLE;
         r.w                      <= RFIE_RST_BYTE;
         r.flags                  <= RFIE_RST_BYTE;
         r.bank_select_reg        <= RFIE_RST_BANK;
         r.pc_upper_latch         <= RFIE_RST_UP;
         r.pc_high_latch          <= RFIE_RST_BYTE;
         r.ready                  <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign hreadyout = r.ready;
   assign hrdata    = r.rdata;
   assign hresp     = r.resp;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [3:0] qcount;

   always_ff @(posedge mclk) begin
      if (sys_rst || r.st == RFIE_ST_IDLE) begin
         qcount <= 4'h0;
      end else if (qtick) begin
         qcount <= qcount + 4'h1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_fire;
      ex_fire;
   endsequence

   // The refused write of a second return op may share the pop edge
   sequence s_fire_quiet;
      ex_fire && (!bus_wr || r.dp_addr == RFIE_A_INSTR);
   endsequence

   a_stack_pop: assert property (s_fire and (r.sp != '0) |=> r.sp == $past(r.sp) - 1'b1)
      else $error("stack not popped by one level");
   a_pc_reload: assert property (s_fire |=> r.pc == $past(top_of_return_stack))
      else $error("pc not loaded from top of stack");
   a_enable_set: assert property (s_fire |=> r.global_high_int_enable || r.periph_low_int_enable)
      else $error("no global enable set on return");
   a_low_enable: assert property (s_fire and r.prio and r.global_high_int_enable
                                  |=> r.periph_low_int_enable)
      else $error("low enable not set at high level");
   a_shadow_copy: assert property (s_fire and r.sbit |=> r.w == $past(r.working_shadow)
      && r.flags == $past(r.flags_shadow) && r.bank_select_reg == $past(r.bank_select_shadow))
      else $error("shadow registers not restored");
   a_no_restore: assert property (s_fire_quiet and !r.sbit |=> $stable(r.w)
                                  && $stable(r.bank_select_reg))
      else $error("registers changed without restore bit");
   a_latch_keep: assert property (s_fire_quiet |=> $stable(r.pc_upper_latch)
                                  && $stable(r.pc_high_latch))
      else $error("pc latches changed by return");
   a_two_cycles: assert property (r.done |-> qcount == RFIE_RUN_TICKS && r.st == RFIE_ST_IDLE)
      else $error("return did not take two instruction cycles");
   a_flags_only: assert property (s_fire_quiet and !r.sbit |=> $stable(r.flags)
                                  && $stable(r.prio))
      else $error("flags changed beyond the enables");

   // ----------------------------------------------------------------
   // Nothing moves outside the pop edge unless software writes it
   // ----------------------------------------------------------------
   sequence s_busy_instr_write;
      r.st != RFIE_ST_IDLE && bus_wr && r.dp_addr == RFIE_A_INSTR;
   endsequence

   a_busy_drop: assert property (s_busy_instr_write |=> $stable(r.iword))
      else $error("instruction word replaced while busy");
   a_cycle_two: assert property (s_fire |=> r.st == RFIE_ST_CYC2 && r.qn == 2'h0)
      else $error("second cycle not entered after the pop");
   a_pc_steady: assert property (!ex_fire && !(bus_wr && r.dp_addr == RFIE_A_PC)
                                 |=> $stable(r.pc))
      else $error("pc changed outside the pop");
   a_sp_steady: assert property (!ex_fire && !(bus_wr && r.dp_addr == RFIE_A_PUSH)
                                 |=> $stable(r.sp))
      else $error("stack pointer moved outside push or pop");
   a_en_steady: assert property (!ex_fire && !(bus_wr && r.dp_addr == RFIE_A_CTRL)
                                 |=> $stable(r.global_high_int_enable)
                                 && $stable(r.periph_low_int_enable))
      else $error("enables changed outside the pop");

endmodule : rfie_core
`default_nettype wire

// ==== logic/rfie_pkg.sv ====
`default_nettype none
package rfie_pkg;

   // ----------------------------------------------------------------
   // Core sizes and clock
   // ----------------------------------------------------------------
   localparam int RFIE_PCW        = 21;
   localparam int RFIE_SPW        = 5;
   localparam int RFIE_DEPTH      = 31;
   localparam int RFIE_CLK_MHZ    = 125;
   localparam int RFIE_QDIV       = 1;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] RFIE_A_INSTR  = 8'h00;
   localparam logic [7:0] RFIE_A_CTRL   = 8'h04;
   localparam logic [7:0] RFIE_A_PC     = 8'h08;
   localparam logic [7:0] RFIE_A_PUSH   = 8'h0c;
   localparam logic [7:0] RFIE_A_WREG   = 8'h10;
   localparam logic [7:0] RFIE_A_FLAGS  = 8'h14;
   localparam logic [7:0] RFIE_A_BANK   = 8'h18;
   localparam logic [7:0] RFIE_A_WSH    = 8'h1c;
   localparam logic [7:0] RFIE_A_FSH    = 8'h20;
   localparam logic [7:0] RFIE_A_BSH    = 8'h24;
   localparam logic [7:0] RFIE_A_PCLAT  = 8'h28;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int RFIE_CTL_GIEH   = 0;
   localparam int RFIE_CTL_GIEL   = 1;
   localparam int RFIE_CTL_PRIO   = 2;
   localparam int RFIE_CTL_BUSY   = 3;
   localparam int RFIE_CTL_SP_LSB = 8;
   localparam int RFIE_PCLAT_UP   = 8;
   localparam int RFIE_SBIT       = 0;

   // ----------------------------------------------------------------
   // Reset values, encodings and counts
   // ----------------------------------------------------------------
   localparam logic [7:0]  RFIE_RST_BYTE  = 8'h00;
   localparam logic [3:0]  RFIE_RST_BANK  = 4'h0;
   localparam logic [4:0]  RFIE_RST_UP    = 5'h00;
   localparam logic [15:0] RFIE_RET_OP    = 16'h0010;
   localparam logic [15:0] RFIE_RET_MASK  = 16'hfffe;
   localparam logic [1:0]  RFIE_LAST_Q    = 2'h3;
   localparam int          RFIE_CYCLES    = 2;
   localparam logic [3:0]  RFIE_RUN_TICKS = 4'h8;
   localparam logic [1:0]  RFIE_HSIZE_W   = 2'h2;

   typedef enum logic [2:0] {
      RFIE_ST_IDLE = 3'b001,
      RFIE_ST_CYC1 = 3'b010,
      RFIE_ST_CYC2 = 3'b100
   } rfie_state_t;

endpackage : rfie_pkg
`default_nettype wire

// ==== logic/rfie_qtick.sv ====
`timescale 1ns/10ps
`default_nettype none
module rfie_qtick #(
   parameter int QDIV = 1
) (
   input  wire logic mclk,
   input  wire logic sys_rst,
   output logic      qtick
);
   import rfie_pkg::*;

   localparam int CW = (QDIV > 1) ? $clog2(QDIV) : 1;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } rfie_qt_t;

   rfie_qt_t r, n;

   // ----------------------------------------------------------------
   // One quarter-phase enable every QDIV clocks
   // ----------------------------------------------------------------
   always_comb begin
      n = r;
      if (r.cnt == CW'(QDIV - 1)) begin
         n.cnt  = '0;
         n.tick = 1'b1;
      end else begin
         n.cnt  = r.cnt + 1'b1;
         n.tick = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign qtick = r.tick;

endmodule : rfie_qtick
`default_nettype wire

// ==== logic/rfie_stack_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
module rfie_stack_mem #(
   parameter int DW = 21,
   parameter int AW = 5
) (
   input  wire logic          mclk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata_r
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // ----------------------------------------------------------------
   // Return stack storage, registered read
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_r <= mem[raddr];
   end

endmodule : rfie_stack_mem
`default_nettype wire

// ==== testbench/return_from_interrupt_exec_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module return_from_interrupt_exec_tb;
   import rfie_pkg::*;

   logic        mclk     = 1'b0;
   logic        sys_rst  = 1'b1;
   logic        hsel     = 1'b0;
   logic [31:0] haddr    = 32'h0;
   logic [1:0]  htrans   = 2'h0;
   logic        hwrite   = 1'b0;
   logic [2:0]  hsize    = 3'h2;
   logic [31:0] hwdata   = 32'h0;
   logic        hready;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   int          n_errors    = 0;
   int          checks_done = 0;
   logic [20:0] stk [$];

   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;

   always #4 mclk = ~mclk;

   rfie_core u_dut (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .hresp     (hresp)
   );

   // ----------------------------------------------------------------
   // Reporting
   // ----------------------------------------------------------------
   task final_report;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report

   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task timed_out;
      n_errors++;
      final_report;
   endtask : timed_out

   // ----------------------------------------------------------------
   // Bus master
   // ----------------------------------------------------------------
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1) begin
         timed_out;
      end
   endtask : wait_rdy

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize  <= 3'b010;
      wait_rdy;
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask : ahb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      ahb(1'b0, a, 32'h0, d);
   endtask : rd

   // Enables after the return: {low, high}
   function automatic logic [1:0] exp_en(input logic prio, input logic gh);
      return {prio & gh, 1'b1};
   endfunction : exp_en

   function automatic logic [31:0] exp_live(input logic s, input logic [31:0] live,
                                            input logic [31:0] shadow);
      return s ? shadow : live;
   endfunction : exp_live

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (100000) @(posedge mclk);
      timed_out;
   end

   initial begin
      logic [31:0] q, pcv, w0, f0, b0, ws, fs, bs, lat, instr, ctl;
      logic        s, prio, ghp;
      int          n;
      logic [7:0]  ra [10];
      void'($urandom(12423));
      ra = '{RFIE_A_INSTR, RFIE_A_CTRL, RFIE_A_PC, RFIE_A_WREG,
             RFIE_A_FLAGS, RFIE_A_BANK, RFIE_A_WSH, RFIE_A_FSH,
             RFIE_A_BSH, RFIE_A_PCLAT};
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      foreach (ra[k]) begin
         rd(ra[k], q);
         chk("reset value", q, 32'h0);
      end
      // Unmapped place: writes vanish, reads give zero
      wr(8'h2c, $urandom);
      rd(8'h2c, q);
      chk("unmapped", q, 32'h0);
      for (int i = 0; i < 8; i++) begin
         s    = i[0];
         prio = i[1];
         ghp  = i[2];
         repeat (2) begin
            pcv = $urandom & 32'h1fffff;
            wr(RFIE_A_PUSH, pcv);
            stk.push_back(pcv[20:0]);
         end
         w0  = $urandom & 32'hff;
         f0  = $urandom & 32'hff;
         b0  = $urandom & 32'hf;
         ws  = $urandom & 32'hff;
         fs  = $urandom & 32'hff;
         bs  = $urandom & 32'hf;
         lat = $urandom & 32'h1fff;
         wr(RFIE_A_WREG, w0);
         wr(RFIE_A_FLAGS, f0);
         wr(RFIE_A_BANK, b0);
         wr(RFIE_A_WSH, ws);
         wr(RFIE_A_FSH, fs);
         wr(RFIE_A_BSH, bs);
         wr(RFIE_A_PCLAT, lat);
         rd(RFIE_A_PUSH, q);
         chk("top of stack", q, {11'h0, stk[$]});
         wr(RFIE_A_CTRL, {29'h0, prio, 1'b0, ghp});
         // Upper half is random to show only the low word decodes
         instr = ($urandom & 32'hffff0000) | 32'h10 | {31'h0, s};
         wr(RFIE_A_INSTR, instr);
         rd(RFIE_A_CTRL, q);
         chk("busy", q & 32'h8, 32'h8);
         // Second op while busy must be dropped
         wr(RFIE_A_INSTR, 32'h11 ^ {31'h0, s});
         n = 0;
         do begin
            rd(RFIE_A_CTRL, q);
            n++;
         end while (q[3] !== 1'b0 && n < 20);
         if (q[3] !== 1'b0) begin
            timed_out;
         end
         pcv = {11'h0, stk.pop_back()};
         ctl = (32'(stk.size()) << RFIE_CTL_SP_LSB) | {29'h0, prio, exp_en(prio, ghp)};
         chk("ctrl", q, ctl);
         rd(RFIE_A_PC, q);
         chk("pc", q, pcv);
         rd(RFIE_A_WREG, q);
         chk("w", q, exp_live(s, w0, ws));
         rd(RFIE_A_FLAGS, q);
         chk("flags", q, exp_live(s, f0, fs));
         rd(RFIE_A_BANK, q);
         chk("bank", q, exp_live(s, b0, bs));
         rd(RFIE_A_PCLAT, q);
         chk("pc latches", q, lat);
         rd(RFIE_A_INSTR, q);
         chk("instr", q, instr & 32'hffff);
      end
      // Words that are not the return op are stored but never run
      for (int i = 0; i < 4; i++) begin
         instr = (i == 0) ? 32'h12 : ($urandom & 32'hffff);
         if ((instr[15:0] & RFIE_RET_MASK) == RFIE_RET_OP) begin
            instr = instr ^ 32'h100;
         end
         rd(RFIE_A_PC, pcv);
         wr(RFIE_A_INSTR, instr);
         rd(RFIE_A_CTRL, q);
         chk("idle", q & 32'h8, 32'h0);
         rd(RFIE_A_PC, q);
         chk("pc kept", q, pcv);
      end
      final_report;
   end

endmodule : return_from_interrupt_exec_tb
`default_nettype wire
